// ### pkg/smt_pkg.sv
// constants, field layout and mode codes of the signal measurement timer
package smt_pkg;
    typedef enum logic [3:0] {
        MODE_TIMER = 4'h0,
        MODE_GATED_TIMER = 4'h1,
        MODE_PERIOD_DUTY = 4'h2,
        MODE_HIGH_LOW = 4'h3,
        MODE_WIN_MEASURE = 4'h4,
        MODE_GATED_WIN = 4'h5,
        MODE_TIME_OF_FLIGHT = 4'h6,
        MODE_CAPTURE = 4'h7,
        MODE_COUNTER = 4'h8,
        MODE_GATED_COUNTER = 4'h9,
        MODE_WIN_COUNTER = 4'ha
    } mode_t;
    typedef enum logic [2:0] {
        CLK_SYS = 3'h0,
        CLK_SYS_DIV4 = 3'h1,
        CLK_FAST = 3'h2,
        CLK_SLOW = 3'h3,
        CLK_MEDIUM_DIV16 = 3'h4
    } clk_src_t;
    // byte offsets on the register bus
    localparam logic [4:0] OFS_COUNTER = 5'h00;
    localparam logic [4:0] OFS_PERIOD_MATCH = 5'h04;
    localparam logic [4:0] OFS_WIDTH_LATCH = 5'h08;
    localparam logic [4:0] OFS_PERIOD_LATCH = 5'h0c;
    localparam logic [4:0] OFS_CONTROL = 5'h10;
    localparam logic [4:0] OFS_STATUS = 5'h14;
    localparam logic [4:0] OFS_FLAGS = 5'h18;
    // control word fields
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_PS_LSB = 4;
    localparam int CTL_HALT = 6;
    localparam int CTL_WPOL = 7;
    localparam int CTL_SPOL = 8;
    localparam int CTL_CPOL = 9;
    localparam int CTL_REPEAT = 10;
    localparam int CTL_NARROW = 11;
    localparam int CTL_CLOCK_SOURCE_SELECT_LSB = 12;
    localparam logic [31:0] CONTROL_MASK = 32'h0000_7fff;
    localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
    // status word fields
    localparam int ST_RUN_REQ = 0;
    localparam int ST_CLEAR = 1;
    localparam int ST_PW_UPD = 2;
    localparam int ST_PR_UPD = 3;
    localparam int ST_RUN_STATE = 8;
    localparam int ST_WIN_LVL = 9;
    localparam int ST_SIG_LVL = 10;
    // event flag fields, write one to clear
    localparam int FL_MATCH = 0;
    localparam int FL_PW = 1;
    localparam int FL_PR = 2;
    // values and counts
    localparam logic [23:0] COUNTER_RST = 24'h00_0000;
    localparam logic [23:0] PERIOD_MATCH_RST = 24'hff_ffff;
    localparam logic [23:0] PERIOD_DUTY_RELOAD = 24'h00_0001;
    localparam logic [23:0] NARROW_MASK = 24'h00_ffff;
    localparam int SYS_DIV = 4;
    localparam int MED_DIV = 16;
endpackage

// ### rtl/signal_measurement_timer.sv
// signal measurement timer: clocking, input sync, counter, latches, Avalon-MM slave
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module signal_measurement_timer #(
    parameter int CNT_W = 24
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // oscillator levels
    input wire logic fast_internal_osc,
    input wire logic slow_internal_osc,
    input wire logic medium_internal_osc,
    // measured inputs
    input wire logic window_input,
    input wire logic signal_input,
    // interrupt flags
    output logic period_match_irq,
    output logic width_acq_irq,
    output logic period_acq_irq
);

    // refuse widths the byte lanes cannot serve
    if (CNT_W < 16 || CNT_W > 24) begin : g_bad_width
        $error("CNT_W must lie between 16 and 24");
    end

    // merge byte lanes of a write into a counter-wide value
    function automatic logic [CNT_W-1:0] merge_lanes(input logic [CNT_W-1:0] old_v,
                                                     input logic [CNT_W-1:0] new_v,
                                                     input logic [3:0] be);
        logic [CNT_W-1:0] r;
        r = old_v;
        for (int i = 0; i < CNT_W; i++) begin
            if (be[i / 8]) begin
                r[i] = new_v[i];
            end
        end
        return r;
    endfunction

    logic [CNT_W-1:0] measure_counter;
    logic [CNT_W-1:0] period_match_value;
    logic [CNT_W-1:0] pulse_width_latch;
    logic [CNT_W-1:0] period_latch;
    logic [31:0] control_word;
    logic run_request;
    logic armed;

    // control fields
    wire [3:0] mode = control_word[smt_pkg::CTL_MODE_LSB +: 4];
    wire [1:0] prescale_select = control_word[smt_pkg::CTL_PS_LSB +: 2];
    wire [2:0] clock_source_select = control_word[smt_pkg::CTL_CLOCK_SOURCE_SELECT_LSB +: 3];
    wire halt_at_match = control_word[smt_pkg::CTL_HALT];
    wire window_polarity = control_word[smt_pkg::CTL_WPOL];
    wire signal_polarity = control_word[smt_pkg::CTL_SPOL];
    wire clock_polarity = control_word[smt_pkg::CTL_CPOL];
    wire repeat_acq = control_word[smt_pkg::CTL_REPEAT];
    wire narrow_mode = control_word[smt_pkg::CTL_NARROW];
    wire [15:0] m = 16'h0001 << mode; // one bit per mode code, reserved codes count nothing
    wire async_mode = m[smt_pkg::MODE_COUNTER] | m[smt_pkg::MODE_GATED_COUNTER] | m[smt_pkg::MODE_WIN_COUNTER];
    wire [CNT_W-1:0] cnt_mask = narrow_mode ? CNT_W'(smt_pkg::NARROW_MASK) : '1;

    // bus decode
    wire acc_wr = avs_write & ~avs_waitrequest;
    wire wr_cnt = acc_wr & (avs_address == smt_pkg::OFS_COUNTER);
    wire wr_pm = acc_wr & (avs_address == smt_pkg::OFS_PERIOD_MATCH);
    wire wr_ctl = acc_wr & (avs_address == smt_pkg::OFS_CONTROL);
    wire wr_stat = acc_wr & (avs_address == smt_pkg::OFS_STATUS) & avs_byteenable[0];
    wire wr_flag = acc_wr & (avs_address == smt_pkg::OFS_FLAGS) & avs_byteenable[0];
    wire sw_clear = wr_stat & avs_writedata[smt_pkg::ST_CLEAR];
    wire sw_pw_upd = wr_stat & avs_writedata[smt_pkg::ST_PW_UPD];
    wire sw_pr_upd = wr_stat & avs_writedata[smt_pkg::ST_PR_UPD];

    // clock source edges and dividers
    logic fast_q;
    logic slow_q;
    logic med_q;
    logic [$clog2(smt_pkg::SYS_DIV)-1:0] sys_div;
    logic [$clog2(smt_pkg::MED_DIV)-1:0] med_div;
    logic [2:0] ps_cnt;
    wire fast_edge = clock_polarity ? (fast_q & ~fast_internal_osc) : (~fast_q & fast_internal_osc);
    wire slow_edge = clock_polarity ? (slow_q & ~slow_internal_osc) : (~slow_q & slow_internal_osc);
    wire med_edge = clock_polarity ? (med_q & ~medium_internal_osc) : (~med_q & medium_internal_osc);
    wire sys4_tick = sys_div == ($clog2(smt_pkg::SYS_DIV))'(smt_pkg::SYS_DIV - 1);
    wire med16_tick = med_edge & (med_div == ($clog2(smt_pkg::MED_DIV))'(smt_pkg::MED_DIV - 1));
    wire src_tick = (clock_source_select == smt_pkg::CLK_SYS) ? 1'b1 :
                    (clock_source_select == smt_pkg::CLK_SYS_DIV4) ? sys4_tick :
                    (clock_source_select == smt_pkg::CLK_FAST) ? fast_edge :
                    (clock_source_select == smt_pkg::CLK_SLOW) ? slow_edge :
                    (clock_source_select == smt_pkg::CLK_MEDIUM_DIV16) ? med16_tick : 1'b0;
    wire [2:0] ps_mask = 3'(4'h7 >> (2'd3 - prescale_select));
    wire ptick = src_tick & ((ps_cnt & ps_mask) == ps_mask);

    // oscillator history and divider counters
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fast_q <= 1'b0;
            slow_q <= 1'b0;
            med_q <= 1'b0;
            sys_div <= '0;
            med_div <= '0;
            ps_cnt <= 3'h0;
        end else begin
            fast_q <= fast_internal_osc;
            slow_q <= slow_internal_osc;
            med_q <= medium_internal_osc;
            sys_div <= sys_div + 1'b1;
            if (med_edge) begin
                med_div <= med_div + 1'b1;
            end
            if (src_tick) begin
                ps_cnt <= ps_cnt + 3'h1;
            end
        end
    end

    // polarity correction ahead of the synchronisers
    wire win_pc = window_input ^ window_polarity;
    wire sig_pc = signal_input ^ signal_polarity;
    logic win_s1;
    logic win_s2;
    logic win_s3;
    logic sig_s1;
    logic sig_s2;
    logic sig_s3;
    logic go_s1;
    logic go_s2;
    logic win_r;
    logic sig_r;

    // synchronisers clocked by the prescaled tick; raw history for counter modes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            {win_s1, win_s2, win_s3} <= 3'h0;
            {sig_s1, sig_s2, sig_s3} <= 3'h0;
            {go_s1, go_s2} <= 2'h0;
            win_r <= 1'b0;
            sig_r <= 1'b0;
        end else begin
            if (ptick) begin
                {win_s3, win_s2, win_s1} <= {win_s2, win_s1, win_pc};
                {sig_s3, sig_s2, sig_s1} <= {sig_s2, sig_s1, sig_pc};
                {go_s2, go_s1} <= {go_s1, run_request};
            end
            win_r <= win_pc;
            sig_r <= sig_pc;
        end
    end

    // selected levels, edges and run state
    wire win_lvl = async_mode ? win_pc : win_s2;
    wire sig_lvl = async_mode ? sig_pc : sig_s2;
    wire win_old = async_mode ? win_r : win_s3;
    wire sig_old = async_mode ? sig_r : sig_s3;
    wire run_state = async_mode ? run_request : go_s2;
    wire en = run_state & (async_mode | ptick);
    wire win_rise = en & win_lvl & ~win_old;
    wire win_fall = en & ~win_lvl & win_old;
    wire sig_rise = en & sig_lvl & ~sig_old;
    wire sig_fall = en & ~sig_lvl & sig_old;

    // per-mode increment gate
    wire inc = en & (m[smt_pkg::MODE_TIMER] | m[smt_pkg::MODE_PERIOD_DUTY] | m[smt_pkg::MODE_CAPTURE]
                | (m[smt_pkg::MODE_GATED_TIMER] & sig_lvl)
                | ((m[smt_pkg::MODE_HIGH_LOW] | m[smt_pkg::MODE_WIN_MEASURE]
                    | m[smt_pkg::MODE_TIME_OF_FLIGHT]) & armed)
                | (m[smt_pkg::MODE_GATED_WIN] & sig_lvl & armed)
                | (m[smt_pkg::MODE_COUNTER] & sig_rise)
                | ((m[smt_pkg::MODE_GATED_COUNTER] | m[smt_pkg::MODE_WIN_COUNTER]) & sig_rise & win_lvl));
    // per-mode capture triggers
    wire cap_pw = ((m[smt_pkg::MODE_GATED_TIMER] | m[smt_pkg::MODE_PERIOD_DUTY]
                    | m[smt_pkg::MODE_HIGH_LOW]) & sig_fall)
                | (m[smt_pkg::MODE_TIME_OF_FLIGHT] & win_rise & armed)
                | ((m[smt_pkg::MODE_CAPTURE] | async_mode) & win_fall);
    wire cap_pr = ((m[smt_pkg::MODE_PERIOD_DUTY] | m[smt_pkg::MODE_HIGH_LOW]) & sig_rise & armed)
                | ((m[smt_pkg::MODE_WIN_MEASURE] | m[smt_pkg::MODE_GATED_WIN]
                    | m[smt_pkg::MODE_WIN_COUNTER]) & win_rise & armed)
                | (m[smt_pkg::MODE_TIME_OF_FLIGHT] & sig_rise & armed)
                | (m[smt_pkg::MODE_CAPTURE] & win_rise);
    // counter restarts; period/duty reloads one, the rest zero
    wire reload = (m[smt_pkg::MODE_PERIOD_DUTY] & sig_rise)
                | (m[smt_pkg::MODE_HIGH_LOW] & (sig_rise | sig_fall))
                | ((m[smt_pkg::MODE_WIN_MEASURE] | m[smt_pkg::MODE_GATED_WIN]) & win_rise)
                | (m[smt_pkg::MODE_TIME_OF_FLIGHT] & (win_rise | (sig_rise & armed)));
    wire [CNT_W-1:0] reload_val = m[smt_pkg::MODE_PERIOD_DUTY] ? CNT_W'(smt_pkg::PERIOD_DUTY_RELOAD)
                                                              : CNT_W'(smt_pkg::COUNTER_RST);
    // arming: first edge opens measurement, later ones complete it
    wire arm_set = (m[smt_pkg::MODE_HIGH_LOW] | m[smt_pkg::MODE_PERIOD_DUTY]) ? sig_rise
                 : (m[smt_pkg::MODE_WIN_MEASURE] | m[smt_pkg::MODE_GATED_WIN]
                    | m[smt_pkg::MODE_TIME_OF_FLIGHT] | m[smt_pkg::MODE_WIN_COUNTER]) & win_rise;
    wire arm_clr = m[smt_pkg::MODE_TIME_OF_FLIGHT] & sig_rise;
    // one acquisition is finished
    wire acq_done = (m[smt_pkg::MODE_GATED_TIMER] | m[smt_pkg::MODE_COUNTER]
                     | m[smt_pkg::MODE_GATED_COUNTER]) ? cap_pw : cap_pr;
    wire single_stop = acq_done & ~repeat_acq;
    wire match = (measure_counter & cnt_mask) == (period_match_value & cnt_mask);
    wire match_evt = inc & match;
    wire [CNT_W-1:0] cnt_plus = (measure_counter + 1'b1) & cnt_mask;

    // measurement counter: software write, clear, restart, match, count
    always_ff @(posedge core_clk) begin
        if (rst) begin
            measure_counter <= CNT_W'(smt_pkg::COUNTER_RST);
        end else if (wr_cnt) begin
            measure_counter <= merge_lanes(measure_counter, avs_writedata[CNT_W-1:0], avs_byteenable) & cnt_mask;
        end else if (sw_clear) begin
            measure_counter <= CNT_W'(smt_pkg::COUNTER_RST);
        end else if (reload) begin
            measure_counter <= reload_val;
        end else if (match_evt) begin
            if (!halt_at_match) begin
                measure_counter <= CNT_W'(smt_pkg::COUNTER_RST);
            end
        end else if (inc) begin
            measure_counter <= cnt_plus;
        end
    end

    // latches: software update or mode trigger
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pulse_width_latch <= '0;
            period_latch <= '0;
        end else begin
            if (sw_pw_upd || cap_pw) begin
                pulse_width_latch <= measure_counter;
            end
            if (sw_pr_upd || cap_pr) begin
                period_latch <= measure_counter;
            end
        end
    end

    // arming state, cleared while stopped
    always_ff @(posedge core_clk) begin
        if (rst || !run_state) begin
            armed <= 1'b0;
        end else if (arm_set) begin
            armed <= 1'b1;
        end else if (arm_clr) begin
            armed <= 1'b0;
        end
    end

    // configuration registers and run request
    always_ff @(posedge core_clk) begin
        if (rst) begin
            control_word <= smt_pkg::CONTROL_RST;
            period_match_value <= CNT_W'(smt_pkg::PERIOD_MATCH_RST);
            run_request <= 1'b0;
        end else begin
            if (wr_ctl) begin
                control_word <= merge_lanes(control_word[CNT_W-1:0], avs_writedata[CNT_W-1:0], avs_byteenable)
                                & smt_pkg::CONTROL_MASK;
            end
            if (wr_pm) begin
                period_match_value <= merge_lanes(period_match_value, avs_writedata[CNT_W-1:0], avs_byteenable);
            end
            if (wr_stat) begin
                run_request <= avs_writedata[smt_pkg::ST_RUN_REQ];
            end else if (single_stop) begin
                run_request <= 1'b0;
            end
        end
    end

    // sticky event flags; a new event wins over a clear in the same cycle
    wire [2:0] flag_clr = wr_flag ? avs_writedata[2:0] : 3'h0;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            period_match_irq <= 1'b0;
            width_acq_irq <= 1'b0;
            period_acq_irq <= 1'b0;
        end else begin
            period_match_irq <= (period_match_irq & ~flag_clr[smt_pkg::FL_MATCH]) | match_evt;
            width_acq_irq <= (width_acq_irq & ~flag_clr[smt_pkg::FL_PW]) | cap_pw;
            period_acq_irq <= (period_acq_irq & ~flag_clr[smt_pkg::FL_PR]) | cap_pr;
        end
    end

    // status levels shown only where meaningful and while running
    wire win_shown = m[smt_pkg::MODE_WIN_MEASURE] | m[smt_pkg::MODE_GATED_COUNTER] | m[smt_pkg::MODE_GATED_WIN];
    wire sig_shown = ~(m[smt_pkg::MODE_WIN_MEASURE] | m[smt_pkg::MODE_TIME_OF_FLIGHT] | m[smt_pkg::MODE_CAPTURE]);
    wire window_level = run_state & win_shown & win_lvl;
    wire signal_level = run_state & sig_shown & sig_lvl;
    wire [31:0] status_word = (32'(run_request) << smt_pkg::ST_RUN_REQ)
                            | (32'(run_state) << smt_pkg::ST_RUN_STATE)
                            | (32'(window_level) << smt_pkg::ST_WIN_LVL)
                            | (32'(signal_level) << smt_pkg::ST_SIG_LVL);
    wire [31:0] flag_word = {29'h0, period_acq_irq, width_acq_irq, period_match_irq};

    // read mux; unmapped offsets read zero
    wire [31:0] read_value = (avs_address == smt_pkg::OFS_COUNTER) ? 32'(measure_counter) :
                             (avs_address == smt_pkg::OFS_PERIOD_MATCH) ? 32'(period_match_value) :
                             (avs_address == smt_pkg::OFS_WIDTH_LATCH) ? 32'(pulse_width_latch) :
                             (avs_address == smt_pkg::OFS_PERIOD_LATCH) ? 32'(period_latch) :
                             (avs_address == smt_pkg::OFS_CONTROL) ? control_word :
                             (avs_address == smt_pkg::OFS_STATUS) ? status_word :
                             (avs_address == smt_pkg::OFS_FLAGS) ? flag_word : 32'h0000_0000;

    // waitrequest drops for one cycle per request; read data registered with it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? read_value : 32'h0000_0000;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    wire hw_quiet = ~wr_cnt & ~sw_clear & ~reload;

    a_clear_zeroes: assert property (sw_clear && !wr_cnt |=> measure_counter == '0)
        else $error("counter not zero after clear request");
    a_width_update: assert property (sw_pw_upd |=> pulse_width_latch == $past(measure_counter))
        else $error("width latch update lost");
    a_period_update: assert property (sw_pr_upd |=> period_latch == $past(measure_counter))
        else $error("period latch update lost");
    a_match_roll: assert property (match_evt && !halt_at_match && hw_quiet
                                   |=> measure_counter == '0 && period_match_irq)
        else $error("no rollover or flag at period match");
    a_halt_hold: assert property (match_evt && halt_at_match && hw_quiet
                                  |=> $stable(measure_counter) && period_match_irq)
        else $error("counter moved while halted at match");
    a_single_stop: assert property (single_stop && !wr_stat |=> !run_request)
        else $error("single acquisition did not stop");
    a_width_capture: assert property (cap_pw && !sw_pw_upd
                                      |=> pulse_width_latch == $past(measure_counter) && width_acq_irq)
        else $error("width capture missing");
    a_period_capture: assert property (cap_pr |=> period_latch == $past(measure_counter))
        else $error("period capture missing");
    a_flag_set_wins: assert property (cap_pr && flag_clr[smt_pkg::FL_PR] |=> period_acq_irq)
        else $error("acquisition flag lost to a clear");
    a_byte_lane: assert property (wr_cnt && avs_byteenable == 4'h1 && !narrow_mode
                                  |=> measure_counter[CNT_W-1:8] == $past(measure_counter[CNT_W-1:8])
                                      && measure_counter[7:0] == $past(avs_writedata[7:0]))
        else $error("counter low lane write disturbed other lanes");
    a_run_sync: assert property (!async_mode && $rose(run_state) |-> $past(ptick))
        else $error("run state changed off the prescaled tick");
    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered in one cycle");

    c_period_duty: cover property (m[smt_pkg::MODE_PERIOD_DUTY] && cap_pr);
    c_halt_match: cover property (match_evt && halt_at_match ##1 match_evt);
    c_single_stop: cover property (single_stop ##1 !run_request);
    c_async_count: cover property (async_mode && inc);

endmodule

// ### test/smt_sources.sv
// far-side source model: signal pulses on request, window held inactive
`timescale 1ns/1ps
module smt_sources #(
    parameter int PULSE_LEN = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // request from the bench
    input wire logic pulse_req,
    // measured lines, synchronous to core_clk
    output logic signal_input,
    output logic window_input
);
    int left;
    // pulse length counter
    always_ff @(posedge core_clk) begin
        if (rst) left <= 0;
        else if (pulse_req) left <= PULSE_LEN;
        else if (left > 0) left <= left - 1;
    end
    assign signal_input = (left > 0);
    assign window_input = 1'b0;
endmodule

// ### test/tb.sv
// self-checking bench for the signal measurement timer
`timescale 1ns/1ps
module tb;
    localparam logic [4:0] CNT = smt_pkg::OFS_COUNTER;
    localparam logic [4:0] ST = smt_pkg::OFS_STATUS;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, window_input, signal_input, pulse_req = 1'b0;
    wire [2:0] irqs;
    int fail_count = 0;
    int tests_run = 0;
    int i;
    initial forever #50 core_clk = ~core_clk;
    signal_measurement_timer DUT (.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fast_internal_osc(1'b0),
        .slow_internal_osc(1'b0), .medium_internal_osc(1'b0), .window_input(window_input),
        .signal_input(signal_input), .period_match_irq(irqs[0]), .width_acq_irq(irqs[1]), .period_acq_irq(irqs[2]));
    smt_sources src (.core_clk(core_clk), .rst(rst), .pulse_req(pulse_req), .signal_input(signal_input),
        .window_input(window_input));
    // one bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
        if (n >= 50) begin
            fail_count++;
            results();
        end
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rc(input logic [4:0] a, input logic [31:0] exp, input string name);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(name, exp, q);
    endtask
    // configure, zero the counter while stopped, then run
    task automatic start(input logic [31:0] ctl, input logic [31:0] pm);
        bus(1'b1, smt_pkg::OFS_CONTROL, ctl, 4'hf);
        bus(1'b1, smt_pkg::OFS_PERIOD_MATCH, pm, 4'hf);
        bus(1'b1, CNT, 32'h0, 4'hf);
        bus(1'b1, ST, 32'h0000_0001, 4'h1);
    endtask
    task automatic wait_irq(input int b);
        for (i = 0; i < 200 && irqs[b] !== 1'b1; i++)
            @(posedge core_clk);
        chk("irq", 32'h1, {31'h0, irqs[b]});
        if (irqs[b] !== 1'b1) begin
            results();
        end
    endtask
    // one signal pulse of the source model, then a quiet gap
    task automatic pulse();
        pulse_req <= 1'b1;
        @(posedge core_clk);
        pulse_req <= 1'b0;
        repeat (12) @(posedge core_clk);
    endtask
    task automatic results();
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rc(smt_pkg::OFS_PERIOD_MATCH, 32'h00ff_ffff, "pm_rst");
        rc(5'h1c, 32'h0, "unmapped");
        bus(1'b1, CNT, 32'h0012_3456, 4'h5);
        rc(CNT, 32'h0012_0056, "cnt_lanes");
        bus(1'b1, CNT, 32'h0000_00ab, 4'h1);
        rc(CNT, 32'h0012_00ab, "cnt_low_lane");
        bus(1'b1, ST, 32'h0000_000c, 4'h1);
        rc(smt_pkg::OFS_WIDTH_LATCH, 32'h0012_00ab, "pw_upd");
        rc(smt_pkg::OFS_PERIOD_LATCH, 32'h0012_00ab, "pr_upd");
        bus(1'b1, ST, 32'h0000_0002, 4'h1);
        rc(CNT, 32'h0, "cnt_clear");
        rc(ST, 32'h0, "self_clear");
        bus(1'b1, smt_pkg::OFS_CONTROL, 32'h0000_0800, 4'hf);
        bus(1'b1, CNT, 32'h00ff_ffff, 4'hf);
        rc(CNT, 32'h0000_ffff, "cnt_narrow");
        $display("test registers done");
        start(32'h0000_0100, 32'h0000_0005);
        wait_irq(0);
        rc(ST, 32'h0000_0501, "run_status");
        bus(1'b1, ST, 32'h0, 4'h1);
        bus(1'b0, CNT, 32'h0, 4'hf);
        chk("cnt_rolled", 32'h1, {31'h0, q[23:0] <= 24'h00_0005});
        bus(1'b1, smt_pkg::OFS_FLAGS, 32'h0000_0001, 4'h1);
        chk("irq_clear", 32'h0, {31'h0, irqs[0]});
        $display("test timer done");
        start(32'h0000_0040, 32'h0000_0003);
        wait_irq(0);
        bus(1'b1, ST, 32'h0, 4'h1);
        rc(CNT, 32'h0000_0003, "cnt_halt");
        chk("irq_holds", 32'h1, {31'h0, irqs[0]});
        $display("test halt done");
        start(32'h0000_0001, 32'h0000_1000);
        bus(1'b1, smt_pkg::OFS_FLAGS, 32'h0000_0007, 4'h1);
        pulse();
        wait_irq(1);
        rc(smt_pkg::OFS_FLAGS, 32'h0000_0002, "flags");
        bus(1'b0, ST, 32'h0, 4'hf);
        chk("run_cleared", 32'h0, q & 32'h1);
        $display("test single done");
        start(32'h0000_0002, 32'h0000_1000);
        bus(1'b1, smt_pkg::OFS_FLAGS, 32'h0000_0007, 4'h1);
        pulse();
        pulse();
        wait_irq(2);
        rc(smt_pkg::OFS_PERIOD_LATCH, 32'h0000_000d, "period");
        rc(smt_pkg::OFS_WIDTH_LATCH, 32'h0000_0008, "width");
        rc(ST, 32'h0, "duty_stopped");
        $display("test duty done");
        start(32'h0000_0008, 32'h0000_1000);
        repeat (3) pulse();
        bus(1'b1, ST, 32'h0, 4'h1);
        rc(CNT, 32'h0000_0003, "cnt_counter");
        $display("test counter done");
        start(32'h0000_1010, 32'h00ff_ffff);
        repeat (80) @(posedge core_clk);
        bus(1'b1, ST, 32'h0, 4'h1);
        repeat (20) @(posedge core_clk);
        bus(1'b0, CNT, 32'h0, 4'hf);
        chk("cnt_prescaled", 32'h1, {31'h0, q[23:0] >= 24'h00_0009 && q[23:0] <= 24'h00_000c});
        $display("test prescale done");
        results();
    end
endmodule
